// File: hw/iscsh_datapath.sv
`timescale 1ns/100ps

module iscsh_datapath
  import iscsh_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Request from decode
  input wire iscsh_req_t req_i,
  // Endianness straps
  input wire logic big_endian_config_i,
  input wire logic reverse_endian_config_i,
  // Write-back and store port
  output iscsh_wb_t wb_o,
  output iscsh_st_t st_o,
  // Events
  output logic addr_err_o,
  output logic nop_o,
  output logic issue_break_o,
  output logic int_overflow_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Split an immediate-format word into its fields
  function automatic iscsh_ifmt_t split_word(input logic [DW-1:0] w);
    iscsh_ifmt_t f;
    f.opcode = w[OPC_LSB +: OPC_W];
    f.reg_hi = w[REGHI_LSB +: REG_W];
    f.reg_lo = w[REGLO_LSB +: REG_W];
    f.imm = w[IMM_LSB +: IMM_W];
    return f;
  endfunction

  // Sign-extend a 16-bit field to a word
  function automatic logic [DW-1:0] sext16(input logic [IMM_W-1:0] v);
    return {{(DW-IMM_W){v[IMM_W-1]}}, v};
  endfunction

  // Boolean result as a word with upper bits clear
  function automatic logic [DW-1:0] bool_word(input logic b);
    return {{(DW-1){1'b0}}, b};
  endfunction

  // ----------------------------------------------------------------
  // State and combinational next value
  // ----------------------------------------------------------------
  iscsh_state_t state;
  iscsh_state_t next_state;
  iscsh_ifmt_t fields;
  logic [DW-1:0] imm_ext;
  logic [DW-1:0] vaddr;
  logic [1:0] bytesel;
  logic endian_be;
  logic endian_re;
  logic is_nop;
  logic is_ssnop;

  // Decode and address arithmetic shared by several operations
  always_comb begin
    fields = split_word(req_i.instr);
    imm_ext = sext16(fields.imm);
    vaddr = req_i.first_source_reg + imm_ext;
    endian_be = state.sync_be[1];
    endian_re = state.sync_re[1];
    bytesel = vaddr[1:0] ^ {endian_be, 1'b0};
    is_nop = req_i.dst_idx == ZERO_REG && req_i.src_idx == ZERO_REG
             && req_i.shift_amount_field == NOP_SA;
    is_ssnop = req_i.dst_idx == ZERO_REG && req_i.src_idx == ZERO_REG
               && req_i.shift_amount_field == SSNOP_SA;
  end

  // Operation select; results land one cycle after the request
  always_comb begin
    next_state = state;
    next_state.sync_be = {state.sync_be[0], big_endian_config_i};
    next_state.sync_re = {state.sync_re[0], reverse_endian_config_i};
    next_state.wb.valid = 1'b0;
    next_state.st.valid = 1'b0;
    next_state.addr_err = 1'b0;
    next_state.nop = 1'b0;
    next_state.issue_break = 1'b0;
    next_state.int_overflow = 1'b0;
    next_state.wb.idx = req_i.dst_idx;
    case (req_i.op)
      OP_SHIFT_LEFT_IMMEDIATE: begin
        if (is_nop) begin
          next_state.nop = 1'b1;
        end else if (is_ssnop) begin
          next_state.issue_break = 1'b1;
        end else begin
          next_state.wb.valid = 1'b1;
          next_state.wb.data = req_i.first_source_reg
                               << req_i.shift_amount_field;
        end
      end
      OP_SHIFT_LEFT_VARIABLE: begin
        next_state.wb.valid = 1'b1;
        next_state.wb.data = req_i.second_source_reg
          << req_i.first_source_reg[SHC_W-1:0];
      end
      OP_SHIFT_RIGHT_ARITH: begin
        next_state.wb.valid = 1'b1;
        next_state.wb.data = DW'($signed(req_i.first_source_reg)
          >>> req_i.shift_amount_field);
      end
      OP_SET_LESS_SIGNED: begin
        next_state.wb.valid = 1'b1;
        next_state.wb.data = bool_word($signed(req_i.first_source_reg)
          < $signed(req_i.second_source_reg));
      end
      OP_SET_LESS_UNSIGNED: begin
        next_state.wb.valid = 1'b1;
        next_state.wb.data = bool_word(req_i.first_source_reg
          < req_i.second_source_reg);
      end
      OP_SET_LESS_SIGNED_IMM: begin
        next_state.wb.valid = 1'b1;
        next_state.wb.idx = fields.reg_hi;
        next_state.wb.data = bool_word($signed(req_i.first_source_reg)
          < $signed(imm_ext));
      end
      OP_SET_LESS_UNSIGNED_IMM: begin
        next_state.wb.valid = 1'b1;
        next_state.wb.idx = fields.reg_hi;
        next_state.wb.data = bool_word(req_i.first_source_reg
          < imm_ext);
      end
      OP_STORE_HALFWORD: begin
        if (vaddr[0]) begin
          next_state.addr_err = 1'b1;
        end else begin
          next_state.st.valid = 1'b1;
          next_state.st.addr = {vaddr[DW-1:2],
                                vaddr[1:0] ^ {endian_re, 1'b0}};
          next_state.st.data = req_i.second_source_reg
                               << {bytesel, 3'b000};
          next_state.st.lanes = HALF_LANES << bytesel;
        end
      end
      default: begin
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign wb_o = state.wb;
  assign st_o = state.st;
  assign addr_err_o = state.addr_err;
  assign nop_o = state.nop;
  assign issue_break_o = state.issue_break;
  assign int_overflow_o = state.int_overflow;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  // Odd halfword address: error and no store
  sh_align_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_STORE_HALFWORD
      && $past(vaddr[0]) |-> addr_err_o && !st_o.valid)
    else $error("odd halfword store not trapped");

  // Aligned halfword store is issued at the computed address
  sh_addr_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_STORE_HALFWORD
      && !$past(vaddr[0])
    |-> st_o.valid && st_o.addr[DW-1:2] == $past(vaddr[DW-1:2]))
    else $error("halfword store address wrong");

  // Halfword data sits on the enabled lanes when they are the low two
  sh_data_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    st_o.valid && st_o.lanes == HALF_LANES
    |-> st_o.data[IMM_W-1:0] == $past(req_i.second_source_reg[IMM_W-1:0]))
    else $error("halfword store data wrong");

  // Exactly two adjacent lanes enabled
  sh_lanes_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    st_o.valid |-> st_o.lanes == HALF_LANES
      || st_o.lanes == (HALF_LANES << 2))
    else $error("halfword store lanes wrong");

  // Immediate left shift result
  shl_imm_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_SHIFT_LEFT_IMMEDIATE
      && !$past(is_nop) && !$past(is_ssnop)
    |-> wb_o.valid && wb_o.data == ($past(req_i.first_source_reg)
      << $past(req_i.shift_amount_field)))
    else $error("immediate left shift wrong");

  // Variable shift ignores upper count bits
  shl_var_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_SHIFT_LEFT_VARIABLE
    |-> wb_o.data == ($past(req_i.second_source_reg)
      << $past(req_i.first_source_reg[SHC_W-1:0])))
    else $error("variable left shift wrong");

  // No-operation encoding writes nothing
  nop_enc_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_SHIFT_LEFT_IMMEDIATE
      && $past(is_nop) |-> nop_o && !wb_o.valid && !issue_break_o)
    else $error("nop encoding mishandled");

  // Issue-break encoding
  ssnop_enc_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_SHIFT_LEFT_IMMEDIATE
      && $past(is_ssnop) |-> issue_break_o && !wb_o.valid && !nop_o)
    else $error("issue break encoding mishandled");

  // Signed register compare
  slt_reg_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_SET_LESS_SIGNED
    |-> wb_o.data == bool_word($signed($past(req_i.first_source_reg))
      < $signed($past(req_i.second_source_reg))))
    else $error("signed compare wrong");

  // Overflow never raised
  no_ovf_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    !int_overflow_o)
    else $error("overflow raised");

  // Signed immediate compare to target field
  set_less_signed_imm_cmp_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_SET_LESS_SIGNED_IMM
    |-> wb_o.idx == $past(req_i.instr[REGHI_LSB +: REG_W])
      && wb_o.data == bool_word($signed($past(req_i.first_source_reg))
      < $signed(sext16($past(req_i.instr[IMM_LSB +: IMM_W])))))
    else $error("signed immediate compare wrong");

  // Unsigned immediate compare after sign extension
  set_less_unsigned_imm_cmp_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_SET_LESS_UNSIGNED_IMM
    |-> wb_o.data == bool_word($past(req_i.first_source_reg)
      < sext16($past(req_i.instr[IMM_LSB +: IMM_W]))))
    else $error("unsigned immediate compare wrong");

  // Unsigned register compare
  set_less_unsigned_reg_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_SET_LESS_UNSIGNED
    |-> wb_o.data == bool_word($past(req_i.first_source_reg)
      < $past(req_i.second_source_reg)))
    else $error("unsigned compare wrong");

  // Arithmetic right shift keeps the sign
  sra_sign_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(req_i.op) == OP_SHIFT_RIGHT_ARITH
    |-> wb_o.data[DW-1] == $past(req_i.first_source_reg[DW-1])
      && wb_o.data == DW'($signed($past(req_i.first_source_reg))
      >>> $past(req_i.shift_amount_field)))
    else $error("arithmetic right shift wrong");

  // Only the halfword store can trap
  trap_src_a: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    addr_err_o |-> $past(req_i.op) == OP_STORE_HALFWORD)
    else $error("exception from shift or compare");

endmodule

// File: hw/iscsh_pkg.sv
package iscsh_pkg;

  // ----------------------------------------------------------------
  // Widths and instruction word fields
  // ----------------------------------------------------------------
  localparam int DW = 32;
  localparam int REG_W = 5;
  localparam int SHC_W = 5;
  localparam int IMM_W = 16;
  localparam int OPC_W = 6;
  localparam int OPC_LSB = 26;
  localparam int REGHI_LSB = 21;
  localparam int REGLO_LSB = 16;
  localparam int IMM_LSB = 0;
  localparam int LANES = 4;

  // Special encodings and lane patterns
  localparam logic [REG_W-1:0] ZERO_REG = 5'h00;
  localparam logic [SHC_W-1:0] NOP_SA = 5'h00;
  localparam logic [SHC_W-1:0] SSNOP_SA = 5'h01;
  localparam logic [LANES-1:0] HALF_LANES = 4'h3;

  // ----------------------------------------------------------------
  // Operations issued by decode
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_STORE_HALFWORD,
    OP_SHIFT_LEFT_IMMEDIATE,
    OP_SHIFT_LEFT_VARIABLE,
    OP_SHIFT_RIGHT_ARITH,
    OP_SET_LESS_SIGNED,
    OP_SET_LESS_UNSIGNED,
    OP_SET_LESS_SIGNED_IMM,
    OP_SET_LESS_UNSIGNED_IMM
  } iscsh_op_t;

  // Request from decode and register file
  typedef struct packed {
    iscsh_op_t op;
    logic [DW-1:0] instr;
    logic [SHC_W-1:0] shift_amount_field;
    logic [REG_W-1:0] src_idx;
    logic [REG_W-1:0] dst_idx;
    logic [DW-1:0] first_source_reg;
    logic [DW-1:0] second_source_reg;
  } iscsh_req_t;

  // Fields of an immediate-format word
  typedef struct packed {
    logic [OPC_W-1:0] opcode;
    logic [REG_W-1:0] reg_hi;
    logic [REG_W-1:0] reg_lo;
    logic [IMM_W-1:0] imm;
  } iscsh_ifmt_t;

  // Register write-back
  typedef struct packed {
    logic valid;
    logic [REG_W-1:0] idx;
    logic [DW-1:0] data;
  } iscsh_wb_t;

  // Memory store port
  typedef struct packed {
    logic valid;
    logic [DW-1:0] addr;
    logic [DW-1:0] data;
    logic [LANES-1:0] lanes;
  } iscsh_st_t;

  // Whole state of the datapath
  typedef struct packed {
    logic [1:0] sync_be;
    logic [1:0] sync_re;
    iscsh_wb_t wb;
    iscsh_st_t st;
    logic addr_err;
    logic nop;
    logic issue_break;
    logic int_overflow;
  } iscsh_state_t;

endpackage

// File: sim/iscsh_sink.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Write-back and store port sink
// ----------------------------------------------------------------
module iscsh_sink
  import iscsh_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Outputs of the datapath
  input wire iscsh_wb_t wb_i,
  input wire iscsh_st_t st_i,
  // Counts of accepted transfers
  output int wr_count_o,
  output int st_count_o
);
  // Count every register write and memory store taken
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      wr_count_o <= 0;
      st_count_o <= 0;
    end else begin
      wr_count_o <= wr_count_o + int'(wb_i.valid);
      st_count_o <= st_count_o + int'(st_i.valid);
    end
  end
endmodule

// File: sim/tb_integer_shift_compare_store_half.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Bench for the shift, compare and halfword store datapath
// ----------------------------------------------------------------
module tb_integer_shift_compare_store_half
  import iscsh_pkg::*;
;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  iscsh_req_t req_i = '0;
  logic big_endian_config_i = 1'b0;
  logic reverse_endian_config_i = 1'b0;
  iscsh_wb_t wb_o;
  iscsh_st_t st_o;
  logic addr_err_o, nop_o, issue_break_o, int_overflow_o;
  int wr_count, st_count, n;
  int fail_count = 0;
  int checks_done = 0;

  // Clock at 50 ns
  always #25 clock_i = ~clock_i;

  iscsh_datapath dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .req_i(req_i),
    .big_endian_config_i(big_endian_config_i),
    .reverse_endian_config_i(reverse_endian_config_i),
    .wb_o(wb_o), .st_o(st_o), .addr_err_o(addr_err_o), .nop_o(nop_o),
    .issue_break_o(issue_break_o), .int_overflow_o(int_overflow_o));

  iscsh_sink sink (
    .clock_i(clock_i), .rstn_i(rstn_i), .wb_i(wb_o), .st_i(st_o),
    .wr_count_o(wr_count), .st_count_o(st_count));

  // Compare one value and count it
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Present one request, then look at the answer one cycle later
  task automatic run(input iscsh_op_t op, input logic [31:0] instr, a, b,
                     input logic [4:0] sa, dst);
    @(posedge clock_i);
    req_i <= '{op, instr, sa, dst, dst, a, b};
    @(posedge clock_i);
    req_i.op <= OP_NONE;
    #1;
  endtask

  // Write-back outcome, overflow always quiet
  task automatic wb_is(input logic v, input logic [4:0] i,
                       input logic [31:0] d);
    check("wb valid", wb_o.valid, v);
    check("overflow", int_overflow_o, 32'h0);
    if (v) begin
      check("wb idx", wb_o.idx, i);
      check("wb data", wb_o.data, d);
    end
  endtask

  // Store outcome, error flag is the inverse of valid
  task automatic st_is(input logic v, input logic [31:0] a, d,
                       input logic [3:0] l);
    check("st valid", st_o.valid, v);
    check("addr err", addr_err_o, !v);
    if (v) begin
      check("st addr", st_o.addr, a);
      check("st data", st_o.data, d);
      check("st lanes", st_o.lanes, l);
    end
  endtask

  // Change the endian straps at an edge, let them pass the synchroniser
  task automatic straps(input logic be, re);
    @(posedge clock_i);
    big_endian_config_i <= be;
    reverse_endian_config_i <= re;
    repeat (3) @(posedge clock_i);
  endtask

  // Aligned stores under each strap setting
  task automatic t_store;
    run(OP_STORE_HALFWORD, 32'h2, 32'h100, 32'h1234abcd, 5'h0, 5'h0);
    st_is(1'b1, 32'h102, 32'habcd0000, 4'hc);
    run(OP_STORE_HALFWORD, 32'hfffc, 32'h200, 32'h1234abcd, 5'h0, 5'h0);
    st_is(1'b1, 32'h1fc, 32'h1234abcd, 4'h3);
    straps(1'b1, 1'b1);
    run(OP_STORE_HALFWORD, 32'h0, 32'h100, 32'h5678, 5'h0, 5'h0);
    st_is(1'b1, 32'h102, 32'h56780000, 4'hc);
    straps(1'b0, 1'b1);
    run(OP_STORE_HALFWORD, 32'h0, 32'h100, 32'h5678, 5'h0, 5'h0);
    st_is(1'b1, 32'h102, 32'h5678, 4'h3);
    straps(1'b1, 1'b0);
    run(OP_STORE_HALFWORD, 32'h2, 32'h100, 32'h5678, 5'h0, 5'h0);
    st_is(1'b1, 32'h102, 32'h5678, 4'h3);
    straps(1'b0, 1'b0);
    $display("test store done");
  endtask

  // Odd addresses refused, odd base with odd offset accepted
  task automatic t_odd;
    n = st_count;
    run(OP_STORE_HALFWORD, 32'h1, 32'h100, 32'h1111, 5'h0, 5'h0);
    st_is(1'b0, 32'h0, 32'h0, 4'h0);
    run(OP_STORE_HALFWORD, 32'h3, 32'h104, 32'h2222, 5'h0, 5'h0);
    st_is(1'b0, 32'h0, 32'h0, 4'h0);
    // One more edge so the sink has counted the last answer
    @(posedge clock_i);
    #1;
    check("stores", st_count - n, 32'h0);
    run(OP_STORE_HALFWORD, 32'hffff, 32'h101, 32'h3333, 5'h0, 5'h0);
    st_is(1'b1, 32'h100, 32'h3333, 4'h3);
    $display("test odd store done");
  endtask

  // Left shifts and arithmetic right shifts
  task automatic t_shift;
    run(OP_SHIFT_LEFT_IMMEDIATE, 32'h0, 32'h80000003, 32'h0, 5'd31, 5'd3);
    wb_is(1'b1, 5'd3, 32'h80000000);
    check("no trap", addr_err_o, 32'h0);
    run(OP_SHIFT_LEFT_VARIABLE, 32'h0, 32'hffffffe5, 32'hff, 5'd0, 5'd4);
    wb_is(1'b1, 5'd4, 32'h1fe0);
    run(OP_SHIFT_RIGHT_ARITH, 32'h0, 32'h80000010, 32'h0, 5'd4, 5'd5);
    wb_is(1'b1, 5'd5, 32'hf8000001);
    run(OP_SHIFT_RIGHT_ARITH, 32'h0, 32'h7ffffff0, 32'h0, 5'd4, 5'd5);
    wb_is(1'b1, 5'd5, 32'h07ffffff);
    $display("test shift done");
  endtask

  // No-operation encodings and a plain shift into register zero
  task automatic t_nop;
    // Let the sink count the previous scenario's last write first
    @(posedge clock_i);
    #1;
    n = wr_count;
    run(OP_SHIFT_LEFT_IMMEDIATE, 32'h0, 32'h0, 32'h0, 5'd0, 5'd0);
    check("nop", nop_o, 32'h1);
    check("break", issue_break_o, 32'h0);
    run(OP_SHIFT_LEFT_IMMEDIATE, 32'h0, 32'h0, 32'h0, 5'd1, 5'd0);
    check("break", issue_break_o, 32'h1);
    check("nop", nop_o, 32'h0);
    #50;
    check("writes", wr_count - n, 32'h0);
    run(OP_SHIFT_LEFT_IMMEDIATE, 32'h0, 32'h0, 32'h0, 5'd2, 5'd0);
    check("nop", nop_o | issue_break_o, 32'h0);
    wb_is(1'b1, 5'd0, 32'h0);
    $display("test nop done");
  endtask

  // Table of signed and unsigned compares
  task automatic t_cmp;
    iscsh_op_t op[10] = '{OP_SET_LESS_SIGNED, OP_SET_LESS_SIGNED,
      OP_SET_LESS_SIGNED, OP_SET_LESS_UNSIGNED, OP_SET_LESS_UNSIGNED,
      OP_SET_LESS_SIGNED_IMM, OP_SET_LESS_SIGNED_IMM,
      OP_SET_LESS_UNSIGNED_IMM, OP_SET_LESS_UNSIGNED_IMM,
      OP_SET_LESS_UNSIGNED_IMM};
    logic [31:0] a[10] = '{32'hffffffff, 32'h7fffffff, 32'h5, 32'h0,
      32'hffffffff, 32'hfffffffe, 32'h0, 32'h5, 32'hfffffffe, 32'hffff9000};
    logic [31:0] b[10] = '{32'h0, 32'h80000000, 32'h5, 32'hffffffff,
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [15:0] imm[10] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hffff,
      16'h8000, 16'hffff, 16'hffff, 16'h8000};
    logic e[10] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1,
      1'b0};
    logic [4:0] ti;
    for (int k = 0; k < 10; k++) begin
      ti = (k < 5) ? 5'd9 : 5'd7;
      run(op[k], {6'h0, 5'd7, 5'd2, imm[k]}, a[k], b[k], 5'd0, 5'd9);
      wb_is(1'b1, ti, {31'h0, e[k]});
      check("cmp idx", wb_o.idx, ti);
      check("no trap", addr_err_o, 32'h0);
    end
    $display("test compare done");
  endtask

  // Report counts and verdict, then stop
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Reset, then each scenario in turn
  initial begin
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_store;
    t_odd;
    t_shift;
    t_nop;
    t_cmp;
    tally_and_finish;
  end
endmodule
